// File: duart_defines.vh
// Purpose: constants for the dual channel register map
// Assumes: 3-bit register address, 8-bit data
// Notes:   offsets are register indices on the parallel bus
`ifndef DUART_DEFINES_VH
`define DUART_DEFINES_VH
`define DUART_ADDR_DATA            3'h0
`define DUART_ADDR_INT_EN          3'h1
`define DUART_ADDR_INT_STAT        3'h2
`define DUART_ADDR_LINE_CTL        3'h3
`define DUART_ADDR_MODEM_CTL       3'h4
`define DUART_ADDR_LINE_STAT       3'h5
`define DUART_ADDR_MODEM_STAT      3'h6
`define DUART_ADDR_SHARED7         3'h7
`define DUART_ENH_CODE             8'hbf
`define DUART_LINE_CTL_DLAB_BIT    7
`define DUART_FEAT_SWAP_BIT        6
`define DUART_ENH_FN_BIT           4
`define DUART_INT_EN_STD_MASK      8'h0f
`define DUART_FIFO_CTL_STD_MASK    8'hcf
`define DUART_MODEM_CTL_STD_MASK   8'h1f
`define DUART_INT_STAT_STD_MASK    8'hcf
`define DUART_MODEM_CTL_RSVD_MASK  8'hfb
`define DUART_MODE_SEL_RSVD_MASK   8'hfb
`define DUART_RESET_ZERO           8'h00
`define DUART_RESET_LINE_STAT      8'h60
`endif

// File: duart_chan.v
// Purpose: one channel register file with shared-address steering
// Assumes: one-cycle read and write strobes, synchronous to clock
// Notes:   receive data, status and levels come from the channel core
`timescale 1ns/100ps
`include "duart_defines.vh"
module duart_chan (
   input  wire       clock,
   input  wire       resetn,
   input  wire       sel,
   input  wire       rd,
   input  wire       wr,
   input  wire [2:0] addr,
   input  wire [7:0] wdata,
   input  wire [7:0] rx_holding,
   input  wire [7:0] interrupt_status,
   input  wire [7:0] line_status,
   input  wire [7:0] modem_status,
   input  wire [7:0] fifo_level_count,
   input  wire [7:0] feature_control,
   input  wire [7:0] enhanced_function,
   output reg  [7:0] rdata,
   output reg        rx_pop,
   output reg        tx_load,
   output reg  [7:0] tx_holding,
   output reg  [7:0] interrupt_enable,
   output reg  [7:0] fifo_control,
   output reg        fifo_write,
   output reg  [7:0] line_control,
   output reg  [7:0] modem_control,
   output reg  [7:0] scratch_pad,
   output reg  [7:0] enhanced_mode_select,
   output reg  [7:0] divisor_low
);
   // decoded selectors
   wire dlab  = line_control[`DUART_LINE_CTL_DLAB_BIT];
   wire enh   = (line_control == `DUART_ENH_CODE);
   wire swap  = feature_control[`DUART_FEAT_SWAP_BIT];
   wire efen  = enhanced_function[`DUART_ENH_FN_BIT];
   wire wr_ok = sel & wr;
   wire rd_ok = sel & rd;
   // enhanced bits masked unless enable bit set
   wire [7:0] int_en_m   = efen ? 8'hff : `DUART_INT_EN_STD_MASK;
   wire [7:0] fifo_ctl_m = efen ? 8'hff : `DUART_FIFO_CTL_STD_MASK;
   wire [7:0] mdm_ctl_m  = efen ? `DUART_MODEM_CTL_RSVD_MASK :
                       (`DUART_MODEM_CTL_STD_MASK &
                        `DUART_MODEM_CTL_RSVD_MASK);
   wire [7:0] int_st_m   = efen ? 8'hff : `DUART_INT_STAT_STD_MASK;

   // register writes; a write never touches the read-only twin
   always @(posedge clock) begin
      if (!resetn) begin
         tx_holding           <= `DUART_RESET_ZERO;
         interrupt_enable     <= `DUART_RESET_ZERO;
         fifo_control         <= `DUART_RESET_ZERO;
         line_control         <= `DUART_RESET_ZERO;
         modem_control        <= `DUART_RESET_ZERO;
         scratch_pad          <= `DUART_RESET_ZERO;
         enhanced_mode_select <= `DUART_RESET_ZERO;
         divisor_low          <= `DUART_RESET_ZERO;
         tx_load              <= 1'b0;
         fifo_write           <= 1'b0;
      end else begin
         tx_load    <= 1'b0;
         fifo_write <= 1'b0;
         if (wr_ok) begin
            case (addr)
               `DUART_ADDR_DATA: begin
                  if (dlab) begin
                     divisor_low <= wdata;
                  end else begin
                     tx_holding <= wdata;
                     tx_load    <= 1'b1;
                  end
               end
               `DUART_ADDR_INT_EN: begin
                  if (!dlab)
                     interrupt_enable <= wdata & int_en_m;
               end
               `DUART_ADDR_INT_STAT: begin
                  if (!enh) begin
                     fifo_control <= wdata & fifo_ctl_m;
                     fifo_write   <= 1'b1;
                  end
               end
               `DUART_ADDR_LINE_CTL: line_control <= wdata;
               `DUART_ADDR_MODEM_CTL: begin
                  if (!enh)
                     modem_control <= wdata & mdm_ctl_m;
               end
               `DUART_ADDR_SHARED7: begin
                  if (!enh && !swap)
                     scratch_pad <= wdata;
                  else if (!enh)
                     enhanced_mode_select <= wdata &
                        `DUART_MODE_SEL_RSVD_MASK;
               end
               default: ; // read-only addresses ignore writes
            endcase
         end
      end
   end

   // read mux; only the receive pop has a side effect
   always @(posedge clock) begin
      if (!resetn) begin
         rdata  <= `DUART_RESET_ZERO;
         rx_pop <= 1'b0;
      end else begin
         rx_pop <= 1'b0;
         if (rd_ok) begin
            case (addr)
               `DUART_ADDR_DATA: begin
                  if (dlab) begin
                     rdata <= divisor_low;
                  end else begin
                     rdata  <= rx_holding;
                     rx_pop <= 1'b1;
                  end
               end
               `DUART_ADDR_INT_EN:
                  rdata <= dlab ? `DUART_RESET_ZERO
                                : (interrupt_enable & int_en_m);
               `DUART_ADDR_INT_STAT:
                  rdata <= enh ? `DUART_RESET_ZERO
                               : (interrupt_status & int_st_m);
               `DUART_ADDR_LINE_CTL: rdata <= line_control;
               // gated like the write, the enhanced set owns it then
               `DUART_ADDR_MODEM_CTL:
                  rdata <= enh ? `DUART_RESET_ZERO
                               : (modem_control & mdm_ctl_m);
               `DUART_ADDR_LINE_STAT:
                  rdata <= enh ? `DUART_RESET_ZERO : line_status;
               `DUART_ADDR_MODEM_STAT: rdata <= modem_status;
               `DUART_ADDR_SHARED7: begin
                  if (enh)
                     rdata <= `DUART_RESET_ZERO;
                  else if (swap)
                     rdata <= fifo_level_count;
                  else
                     rdata <= scratch_pad;
               end
               default: rdata <= `DUART_RESET_ZERO;
            endcase
         end
      end
   end
endmodule // duart_chan

// File: duart_top.v
// Function
// - read addr 0 gives receive byte
// - write addr 0 loads transmit byte
// - addr 1 interrupt enable when dlab clear
// - addr 2 read gives interrupt status
// - addr 2 write loads fifo control
// - addr 3 line control read write
// - addr 4 modem control read write
// - addr 5 read gives line status
// - addr 6 read gives modem status
// - addr 7 scratch when swap bit clear
// - addr 7 write enhanced mode when swap
// - addr 7 read level count when swap
// - enhanced bits need enable bit set
// - two identical independent channel register maps
// - dlab set maps addr 0 divisor low
//
// Purpose: dual channel register front end on a parallel bus
// Assumes: strobes and selects synchronous to clock, active low
// Notes:   read and write strobes are edge detected to one pulse
`timescale 1ns/100ps
`include "duart_defines.vh"
module duart_top (
   input  wire        clock,
   input  wire        resetn,
   input  wire        chan_a_select_n,
   input  wire        chan_b_select_n,
   input  wire        read_n,
   input  wire        write_n,
   input  wire [2:0]  addr,
   input  wire [7:0]  wdata,
   input  wire [15:0] rx_holding,
   input  wire [15:0] interrupt_status,
   input  wire [15:0] line_status,
   input  wire [15:0] modem_status,
   input  wire [15:0] fifo_level_count,
   input  wire [15:0] feature_control,
   input  wire [15:0] enhanced_function,
   output reg  [7:0]  rdata,
   output wire [1:0]  rx_pop,
   output wire [1:0]  tx_load,
   output wire [15:0] tx_holding,
   output wire [15:0] interrupt_enable,
   output wire [15:0] fifo_control,
   output wire [1:0]  fifo_write,
   output wire [15:0] line_control,
   output wire [15:0] modem_control,
   output wire [15:0] scratch_pad,
   output wire [15:0] enhanced_mode_select,
   output wire [15:0] divisor_low
);
   reg         rd_d;      // delayed read strobe
   reg         wr_d;      // delayed write strobe
   reg         rd_pick_b; // channel b answered the last read
   wire [15:0] ch_rd;     // per channel read data
   wire        rd_p;      // read taken this cycle
   wire        wr_p;      // write taken this cycle

   assign rd_p = ~read_n & ~rd_d;
   assign wr_p = ~write_n & ~wr_d;

   // strobe history so an access counts once per assertion
   always @(posedge clock) begin
      if (!resetn) begin
         rd_d      <= 1'b0;
         wr_d      <= 1'b0;
         rd_pick_b <= 1'b0;
      end else begin
         rd_d <= ~read_n;
         wr_d <= ~write_n;
         // keep the answering channel, rdata must outlive the select
         if (rd_p && (~chan_a_select_n | ~chan_b_select_n))
            rd_pick_b <= chan_a_select_n;
      end
   end

   // one identical copy per channel
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gch
         wire s = (g == 0) ? ~chan_a_select_n : ~chan_b_select_n;
         duart_chan u_ch (
            .clock                (clock),
            .resetn               (resetn),
            .sel                  (s),
            .rd                   (rd_p),
            .wr                   (wr_p),
            .addr                 (addr),
            .wdata                (wdata),
            .rx_holding           (rx_holding[g*8 +: 8]),
            .interrupt_status     (interrupt_status[g*8 +: 8]),
            .line_status          (line_status[g*8 +: 8]),
            .modem_status         (modem_status[g*8 +: 8]),
            .fifo_level_count     (fifo_level_count[g*8 +: 8]),
            .feature_control      (feature_control[g*8 +: 8]),
            .enhanced_function    (enhanced_function[g*8 +: 8]),
            .rdata                (ch_rd[g*8 +: 8]),
            .rx_pop               (rx_pop[g]),
            .tx_load              (tx_load[g]),
            .tx_holding           (tx_holding[g*8 +: 8]),
            .interrupt_enable     (interrupt_enable[g*8 +: 8]),
            .fifo_control         (fifo_control[g*8 +: 8]),
            .fifo_write           (fifo_write[g]),
            .line_control         (line_control[g*8 +: 8]),
            .modem_control        (modem_control[g*8 +: 8]),
            .scratch_pad          (scratch_pad[g*8 +: 8]),
            .enhanced_mode_select (enhanced_mode_select[g*8 +: 8]),
            .divisor_low          (divisor_low[g*8 +: 8])
         );
      end
   endgenerate

   // last read channel drives rdata; a wins if both selects are low
   always @* begin
      rdata = rd_pick_b ? ch_rd[15:8] : ch_rd[7:0];
   end
endmodule // duart_top

// File: duart_top_chk.sv
// Purpose: port checker for the dual channel register front end
// Assumes: strobes sampled on clock, access taken on first low cycle
// Notes:   channel a takes are watched, channel b only for isolation
`timescale 1ns/100ps
module duart_top_chk (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        chan_a_select_n,
   input wire logic        chan_b_select_n,
   input wire logic        read_n,
   input wire logic        write_n,
   input wire logic [2:0]  addr,
   input wire logic [7:0]  wdata,
   input wire logic [15:0] rx_holding,
   input wire logic [15:0] feature_control,
   input wire logic [7:0]  rdata,
   input wire logic [1:0]  rx_pop,
   input wire logic [1:0]  tx_load,
   input wire logic [1:0]  fifo_write,
   input wire logic [15:0] tx_holding,
   input wire logic [15:0] interrupt_enable,
   input wire logic [15:0] line_control,
   input wire logic [15:0] scratch_pad,
   input wire logic [15:0] divisor_low
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic rd_q;   // strobe levels one cycle back
   logic wr_q;
   // edge detect in logic, sampled functions stay out of assigns
   always @(posedge clock) begin
      rd_q <= read_n;
      wr_q <= write_n;
   end
   wire rd_a = rd_q & !read_n & !chan_a_select_n;
   wire wr_a = wr_q & !write_n & !chan_a_select_n;
   wire dlab = line_control[7];
   wire enh  = line_control[7:0] == 8'hbf;
   property p_rx_rd;
      rd_a && addr == 3'h0 && !dlab |=>
         rx_pop[0] && rdata == $past(rx_holding[7:0]);
   endproperty
   a_rx_rd: assert property (p_rx_rd) else $error("receive read wrong");
   property p_tx_wr;
      wr_a && addr == 3'h0 && !dlab |=>
         tx_load[0] && tx_holding[7:0] == $past(wdata);
   endproperty
   a_tx_wr: assert property (p_tx_wr) else $error("transmit load wrong");
   property p_line_ctl;
      wr_a && addr == 3'h3 |=> line_control[7:0] == $past(wdata);
   endproperty
   a_line_ctl: assert property (p_line_ctl)
      else $error("line control wrong");
   property p_fifo_ctl;
      wr_a && addr == 3'h2 && !enh |=> fifo_write[0];
   endproperty
   a_fifo_ctl: assert property (p_fifo_ctl)
      else $error("fifo write missing");
   property p_scratch;
      wr_a && addr == 3'h7 && !enh && !feature_control[6] |=>
         scratch_pad[7:0] == $past(wdata);
   endproperty
   a_scratch: assert property (p_scratch)
      else $error("scratch write wrong");
   property p_dll;
      wr_a && addr == 3'h0 && dlab && !enh |=>
         divisor_low[7:0] == $past(wdata) && !tx_load[0];
   endproperty
   a_dll: assert property (p_dll) else $error("divisor write wrong");
   property p_no_pop;
      wr_a |=> rx_pop == 2'b00;
   endproperty
   a_no_pop: assert property (p_no_pop) else $error("write popped");
   property p_int_en_dlab;
      wr_a && addr == 3'h1 && dlab |=> $stable(interrupt_enable[7:0]);
   endproperty
   a_int_en_dlab: assert property (p_int_en_dlab)
      else $error("interrupt enable hit");
   property p_iso;
      wr_a && chan_b_select_n |=> $stable(line_control[15:8]);
   endproperty
   a_iso: assert property (p_iso) else $error("channel b disturbed");
   c_rx: cover property (rd_a && addr == 3'h0);
   c_dll: cover property (wr_a && dlab);
   c_swap: cover property (wr_a && feature_control[6]);
endmodule // duart_top_chk

bind duart_top duart_top_chk u_duart_top_chk (.clock, .resetn,
   .chan_a_select_n, .chan_b_select_n, .read_n, .write_n, .addr, .wdata,
   .rx_holding, .feature_control, .rdata, .rx_pop, .tx_load, .fifo_write,
   .tx_holding, .interrupt_enable, .line_control, .scratch_pad,
   .divisor_low);

// File: duart_host_bfm.sv
// Purpose: host processor model on the parallel register bus
// Assumes: one access per two cycles, strobe high between accesses
// Notes:   released bus shows inverted values, never the old ones
`timescale 1ns/100ps
module duart_host_bfm (
   input  wire logic       clock,
   output logic            chan_a_select_n,
   output logic            chan_b_select_n,
   output logic            read_n,
   output logic            write_n,
   output logic [2:0]      addr,
   output logic [7:0]      wdata,
   input  wire logic [7:0] rdata
);
   // idle bus at time zero
   initial begin
      chan_a_select_n = 1'b1;
      chan_b_select_n = 1'b1;
      read_n = 1'b1;
      write_n = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
   end
   // one access; channel picked by its own select line
   task xfer(input logic [1:0] ch, input logic w, input logic [2:0] a,
             input logic [7:0] d, output logic [7:0] q);
      @(negedge clock);
      chan_a_select_n <= !ch[0];
      chan_b_select_n <= !ch[1];
      addr <= a;
      wdata <= d;
      read_n <= w;
      write_n <= !w;
      @(negedge clock);
      q = rdata;
      read_n <= 1'b1;
      write_n <= 1'b1;
      chan_a_select_n <= 1'b1;
      chan_b_select_n <= 1'b1;
      addr <= ~a;
      wdata <= ~d;
   endtask
endmodule // duart_host_bfm

// File: duart_top_tb.sv
// Purpose: register map scenarios for both channels
// Assumes: core side inputs are bench levels, fixed except the enable and swap bits
// Notes:   expected bytes come from the masks of the register layout
`timescale 1ns/100ps
module duart_top_tb;
   logic clock, resetn, chan_a_select_n, chan_b_select_n, read_n, write_n;
   logic [2:0]  addr;
   logic [7:0]  wdata, rdata, q;
   logic [15:0] rx_holding = 16'h7e81, interrupt_status = 16'h00ff;
   logic [15:0] line_status = 16'h0060, modem_status = 16'h0a5c;
   logic [15:0] fifo_level_count = 16'h1122, feature_control = 16'h0000;
   logic [15:0] enhanced_function = 16'h0000;
   logic [15:0] tx_holding, fifo_control, line_control, scratch_pad;
   logic [15:0] enhanced_mode_select, divisor_low;
   logic [15:0] interrupt_enable, modem_control;
   logic [1:0]  rx_pop, tx_load, fifo_write;
   int miscompares = 0;
   int checked = 0;
   duart_top u_duart_top (.clock, .resetn, .chan_a_select_n,
      .chan_b_select_n, .read_n, .write_n, .addr, .wdata, .rx_holding,
      .interrupt_status, .line_status, .modem_status, .fifo_level_count,
      .feature_control, .enhanced_function, .rdata, .rx_pop, .tx_load,
      .tx_holding, .interrupt_enable, .fifo_control, .fifo_write,
      .line_control, .modem_control, .scratch_pad, .enhanced_mode_select,
      .divisor_low);
   duart_host_bfm u_duart_host_bfm (.clock, .chan_a_select_n,
      .chan_b_select_n, .read_n, .write_n, .addr, .wdata, .rdata);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task wr(input logic [1:0] c, input logic [2:0] a, input logic [7:0] d);
      u_duart_host_bfm.xfer(c, 1'b1, a, d, q);
   endtask
   task rd(input logic [1:0] c, input logic [2:0] a);
      u_duart_host_bfm.xfer(c, 1'b0, a, 8'h00, q);
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task final_report;
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog, far beyond the sixty or so cycles the tests need
   initial begin
      #100000;
      miscompares++;
      final_report;
   end
   initial begin
      resetn = 1'b0;
      repeat (6) @(negedge clock);
      resetn = 1'b1;
      chk("line ctl reset", 8'h00, line_control[7:0]);
      wr(1, 3, 8'h03); rd(1, 3); chk("line ctl", 8'h03, q);
      wr(1, 1, 8'hff); rd(1, 1); chk("int en std", 8'h0f, q);
      enhanced_function[4] = 1'b1;
      wr(1, 1, 8'hff); rd(1, 1); chk("int en enh", 8'hff, q);
      enhanced_function[4] = 1'b0;
      wr(1, 0, 8'h5a); chk("tx byte", 8'h5a, tx_holding[7:0]);
      chk("tx load", 8'h01, {6'h00, tx_load});
      rd(1, 0); chk("rx byte", 8'h81, q);
      chk("rx pop", 8'h01, {6'h00, rx_pop});
      rd(1, 2); chk("int status", 8'hcf, q);
      rd(1, 5); chk("line status", 8'h60, q);
      rd(1, 6); chk("modem status", 8'h5c, q);
      wr(1, 4, 8'hff); rd(1, 4); chk("modem ctl", 8'h1b, q);
      chk("modem ctl out", 8'h1b, modem_control[7:0]);
      wr(1, 2, 8'hff); chk("fifo ctl", 8'hcf, fifo_control[7:0]);
      chk("fifo write", 8'h01, {6'h00, fifo_write});
      wr(1, 7, 8'ha5); rd(1, 7); chk("scratch", 8'ha5, q);
      feature_control[6] = 1'b1;
      wr(1, 7, 8'hff);
      chk("mode sel", 8'hfb, enhanced_mode_select[7:0]);
      rd(1, 7); chk("fifo level", 8'h22, q);
      chk("scratch kept", 8'ha5, scratch_pad[7:0]);
      wr(1, 3, 8'h83); wr(1, 0, 8'h12);
      chk("no tx load", 8'h00, {6'h00, tx_load});
      rd(1, 0); chk("divisor low", 8'h12, q);
      chk("no rx pop", 8'h00, {6'h00, rx_pop});
      chk("tx byte kept", 8'h5a, tx_holding[7:0]);
      wr(1, 1, 8'h00);
      chk("int en kept", 8'hff, interrupt_enable[7:0]);
      wr(1, 3, 8'hbf); rd(1, 5); chk("status gated", 8'h00, q);
      wr(2, 3, 8'h07); rd(2, 3); chk("line ctl b", 8'h07, q);
      chk("line ctl a kept", 8'hbf, line_control[7:0]);
      final_report;
   end
endmodule // duart_top_tb
